// ===== dv/can_bus_node.sv
`default_nettype none
module can_bus_node (
    input  wire logic clk_sys,
    input  wire logic run,
    input  wire logic dominant,
    output logic      bus_rx,
    output logic      quantum_tick,
    output logic      sample_tick,
    output logic      bit_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    always_ff @(posedge clk_sys) begin
        phase <= run ? phase + 2'h1 : 2'h0;
    end
    // Ticks stand still outside frames; four quanta per bit keeps recovery short
    assign quantum_tick = run;
    assign sample_tick  = run && (phase == 2'h2);
    assign bit_tick     = run && (phase == 2'h3);
    // Idle bus is recessive
    assign bus_rx       = !dominant;
endmodule : can_bus_node
`default_nettype wire

// ===== dv/can_flags_checker_asserts.sv
`default_nettype none
module can_flags_checker
    import can_timing_flags_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       sample_tick,
    input wire logic       sampled_bit,
    input wire logic       triple_vote_sel,
    input wire logic [3:0] phase_span_one,
    input wire logic [2:0] phase_span_two,
    input wire logic [4:0] seg_one_quanta,
    input wire logic [3:0] seg_two_quanta,
    input wire logic [5:0] quanta_per_bit,
    input wire logic       soft_reset_req,
    input wire logic       transfer_abort,
    input wire logic       exchange_allowed,
    input wire logic       wake_irq,
    input wire logic       error_irq,
    input wire logic       rx_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_seg1; seg_one_quanta == 5'(phase_span_one) + 5'h01; endproperty
    a_seg1: assert property (p_seg1) else $error("segment one length wrong");
    property p_seg2; seg_two_quanta == 4'(phase_span_two) + 4'h1; endproperty
    a_seg2: assert property (p_seg2) else $error("segment two length wrong");
    property p_bit_len; quanta_per_bit == 6'h01 + 6'(seg_one_quanta) + 6'(seg_two_quanta); endproperty
    a_bit_len: assert property (p_bit_len) else $error("quanta per bit wrong");
    property p_lock; !soft_reset_req |=> $stable({triple_vote_sel, phase_span_two, phase_span_one}); endproperty
    a_lock: assert property (p_lock) else $error("bit timing changed outside soft reset");
    property p_abort; transfer_abort == soft_reset_req; endproperty
    a_abort: assert property (p_abort) else $error("abort does not follow soft reset");
    // Two cycles, since flags clear one edge after the request lands
    property p_held; soft_reset_req [*2] |-> !wake_irq && !error_irq && !rx_irq; endproperty
    a_held: assert property (p_held) else $error("interrupt during soft reset");
    property p_rx_block; rx_irq |-> !exchange_allowed; endproperty
    a_rx_block: assert property (p_rx_block) else $error("exchange while receive full");
    property p_soft_exch; soft_reset_req |-> !exchange_allowed; endproperty
    a_soft_exch: assert property (p_soft_exch) else $error("exchange during soft reset");
    property p_sample; !sample_tick |=> $stable(sampled_bit); endproperty
    a_sample: assert property (p_sample) else $error("sampled bit moved off sample point");
endmodule : can_flags_checker
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench
    import can_timing_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0]            reg_addr = 4'h0, phase_span_one, seg_two_quanta;
    logic [7:0]            reg_wdata = 8'h00, reg_rdata;
    logic [8:0]            rx_error_count = 9'h000, tx_error_count = 9'h000;
    logic                  overrun_event = 1'b0, rx_message_done = 1'b0, run = 1'b0, dominant = 1'b0;
    logic [TX_BUFFERS-1:0] tx_done = 3'h0, tx_aborted = 3'h0;
    logic                  bus_rx, quantum_tick, sample_tick, bit_tick, sampled_bit, triple_vote_sel;
    logic [2:0]            phase_span_two;
    logic [4:0]            seg_one_quanta;
    logic [5:0]            quanta_per_bit, prescale_value;
    logic                  soft_reset_req, transfer_abort, exchange_allowed, wake_irq, error_irq, rx_irq;
    int                    miscompares = 0, n_tests = 0, cycles = 0;
    // Row: written value, segment one, segment two, quanta per bit
    logic [31:0]           rows [4] = '{32'h2304_0308, 32'hF304_080D, 32'h1F10_0213, 32'hC506_050C};
    always #5 clk_sys = ~clk_sys;
    can_timing_error_flags dut_u (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .bus_rx, .quantum_tick, .sample_tick, .bit_tick, .rx_error_count, .tx_error_count, .overrun_event,
        .rx_message_done, .tx_done, .tx_aborted, .sampled_bit, .triple_vote_sel, .phase_span_one,
        .phase_span_two, .seg_one_quanta, .seg_two_quanta, .quanta_per_bit, .prescale_value, .soft_reset_req,
        .transfer_abort, .exchange_allowed, .wake_irq, .error_irq, .rx_irq);
    can_bus_node node_u (.clk_sys, .run, .dominant, .bus_rx, .quantum_tick, .sample_tick, .bit_tick);
    // ****************************************
    // Bus tasks and report
    // ****************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata & m);
    endtask : rd
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Ceiling well above the bus-off recovery run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_MODE_CTRL, 8'hFF, MODE_CTRL_RESET);
        rd(ADDR_RX_FLAGS, 8'hFF, BYTE_ZERO);
        rd(ADDR_RX_IRQ_EN, 8'hFF, BYTE_ZERO);
        rd(ADDR_TX_FLAGS, 8'hFF, {5'h00, TX_EMPTY_RESET});
        rd(4'h9, 8'hFF, BYTE_ZERO);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_BIT_TIMING, rows[i][31:24]);
            chk("seg_one_quanta", rows[i][23:16], {3'h0, seg_one_quanta});
            chk("seg_two_quanta", rows[i][15:8], {4'h0, seg_two_quanta});
            chk("quanta_per_bit", rows[i][7:0], {2'h0, quanta_per_bit});
            rd(ADDR_BIT_TIMING, 8'hFF, rows[i][31:24]);
        end
        wr(ADDR_PRESCALE, 8'h05);
        chk("prescale_value", 8'h05, {2'h0, prescale_value});
        wr(ADDR_MODE_CTRL, BYTE_ZERO);
        chk("transfer_abort", 8'h00, {7'h00, transfer_abort});
        wr(ADDR_BIT_TIMING, 8'h23);
        rd(ADDR_BIT_TIMING, 8'hFF, 8'hC5);
        @(posedge clk_sys) rx_error_count <= 9'h060;
        rd(ADDR_RX_FLAGS, 8'hFF, BYTE_ZERO);
        @(posedge clk_sys) rx_error_count <= 9'h061;
        wr(ADDR_RX_IRQ_EN, 8'h40);
        rd(ADDR_RX_FLAGS, 8'hFF, 8'h40);
        chk("error_irq", 8'h01, {7'h00, error_irq});
        wr(ADDR_RX_FLAGS, 8'h40);
        rd(ADDR_RX_FLAGS, 8'hFF, 8'h40);
        @(posedge clk_sys) rx_error_count <= 9'h000;
        wr(ADDR_RX_FLAGS, 8'hBF);
        rd(ADDR_RX_FLAGS, 8'hFF, 8'h40);
        wr(ADDR_RX_FLAGS, 8'h40);
        rd(ADDR_RX_FLAGS, 8'hFF, BYTE_ZERO);
        chk("error_irq", 8'h00, {7'h00, error_irq});
        @(posedge clk_sys) rx_error_count <= 9'h080;
        tx_error_count <= 9'h080;
        rd(ADDR_RX_FLAGS, 8'h18, 8'h18);
        @(posedge clk_sys) tx_error_count <= 9'h100;
        rd(ADDR_RX_FLAGS, 8'h04, 8'h04);
        @(posedge clk_sys) tx_error_count <= 9'h000;
        rx_error_count <= 9'h000;
        wr(ADDR_RX_FLAGS, 8'hFF);
        rd(ADDR_RX_FLAGS, 8'hFF, 8'h04);
        @(posedge clk_sys) run <= 1'b1;
        repeat (400) @(posedge clk_sys);
        wr(ADDR_RX_FLAGS, 8'h04);
        rd(ADDR_RX_FLAGS, 8'h04, 8'h04);
        repeat (5400) @(posedge clk_sys);
        wr(ADDR_RX_FLAGS, 8'h04);
        rd(ADDR_RX_FLAGS, 8'hFF, BYTE_ZERO);
        dominant <= 1'b1;
        repeat (7) @(posedge clk_sys);
        #1 chk("sampled_bit", 8'h00, {7'h00, sampled_bit});
        dominant <= 1'b0;
        repeat (7) @(posedge clk_sys);
        #1 chk("sampled_bit", 8'h01, {7'h00, sampled_bit});
        run <= 1'b0;
        @(posedge clk_sys) overrun_event <= 1'b1;
        wr(ADDR_RX_FLAGS, 8'h02);
        @(posedge clk_sys) overrun_event <= 1'b0;
        rd(ADDR_RX_FLAGS, 8'hFF, 8'h02);
        @(posedge clk_sys) rx_message_done <= 1'b1;
        @(posedge clk_sys) rx_message_done <= 1'b0;
        wr(ADDR_RX_IRQ_EN, 8'h83);
        rd(ADDR_RX_FLAGS, 8'hFF, 8'h03);
        chk("irqs", 8'h03, {6'h00, error_irq, rx_irq});
        chk("exchange_allowed", 8'h00, {7'h00, exchange_allowed});
        wr(ADDR_MODE_CTRL, 8'h02);
        @(posedge clk_sys) dominant <= 1'b1;
        @(posedge clk_sys) dominant <= 1'b0;
        rd(ADDR_RX_FLAGS, 8'h80, 8'h80);
        chk("wake_irq", 8'h01, {7'h00, wake_irq});
        wr(ADDR_TX_FLAGS, 8'h03);
        rd(ADDR_TX_FLAGS, 8'hFF, 8'h04);
        @(posedge clk_sys) tx_done <= 3'h1;
        tx_aborted <= 3'h2;
        @(posedge clk_sys) tx_done <= 3'h0;
        tx_aborted <= 3'h0;
        wr(ADDR_TX_FLAGS, 8'h20);
        rd(ADDR_TX_FLAGS, 8'hFF, 8'h27);
        wr(ADDR_TX_FLAGS, 8'h02);
        rd(ADDR_TX_FLAGS, 8'hFF, 8'h05);
        wr(ADDR_MODE_CTRL, 8'h01);
        wr(ADDR_RX_IRQ_EN, 8'hFF);
        @(posedge clk_sys) rx_message_done <= 1'b1;
        @(posedge clk_sys) rx_message_done <= 1'b0;
        rd(ADDR_RX_FLAGS, 8'hFF, BYTE_ZERO);
        rd(ADDR_RX_IRQ_EN, 8'hFF, BYTE_ZERO);
        rd(ADDR_TX_FLAGS, 8'hFF, {5'h00, TX_EMPTY_RESET});
        chk("irqs", 8'h00, {5'h00, wake_irq, error_irq, rx_irq});
        summarize();
    end
endmodule : testbench
bind can_timing_error_flags can_flags_checker checker_u (.clk_sys, .rst_n, .sample_tick, .sampled_bit,
    .triple_vote_sel, .phase_span_one, .phase_span_two, .seg_one_quanta, .seg_two_quanta, .quanta_per_bit,
    .soft_reset_req, .transfer_abort, .exchange_allowed, .wake_irq, .error_irq, .rx_irq);
`default_nettype wire

// ===== rtl/can_timing_error_flags.sv
// Decided for this implementation: the register offsets and strobed register access.
`default_nettype none
module can_timing_error_flags
    import can_timing_flags_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [3:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  bus_rx,
    input  wire logic                  quantum_tick,
    input  wire logic                  sample_tick,
    input  wire logic                  bit_tick,
    input  wire logic [8:0]            rx_error_count,
    input  wire logic [8:0]            tx_error_count,
    input  wire logic                  overrun_event,
    input  wire logic                  rx_message_done,
    input  wire logic [TX_BUFFERS-1:0] tx_done,
    input  wire logic [TX_BUFFERS-1:0] tx_aborted,
    output logic                       sampled_bit,
    output logic                       triple_vote_sel,
    output logic      [3:0]            phase_span_one,
    output logic      [2:0]            phase_span_two,
    output logic      [4:0]            seg_one_quanta,
    output logic      [3:0]            seg_two_quanta,
    output logic      [5:0]            quanta_per_bit,
    output logic      [5:0]            prescale_value,
    output logic                       soft_reset_req,
    output logic                       transfer_abort,
    output logic                       exchange_allowed,
    output logic                       wake_irq,
    output logic                       error_irq,
    output logic                       rx_irq
);
    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]            mode_ctrl;
    logic [7:0]            prescale;
    logic [7:0]            bit_timing_segments;
    logic [7:0]            receiver_status_flags;
    logic [7:0]            receiver_interrupt_enables;
    logic [TX_BUFFERS-1:0] abort_ack_flag;
    logic [TX_BUFFERS-1:0] tx_empty_flag;
    logic [7:0]            transmit_status_flags;
    logic [7:0]            flag_set;
    logic [7:0]            flag_cond;
    logic [7:0]            wr_clear;
    logic                  bus_off_flag;
    logic                  sleep_mode;
    logic                  bus_prev;
    logic [2:0]            sample_hist;
    logic [3:0]            run_count;
    logic [7:0]            run_total;
    logic                  recovered;
    logic                  hard_or_soft;
    logic                  mode_write;
    logic                  prescale_write;
    logic                  timing_write;
    logic                  rx_flags_write;
    logic                  rx_en_write;
    logic                  tx_flags_write;
    logic                  rx_over_warn;
    logic                  tx_over_warn;
    logic                  rx_over_passive;
    logic                  tx_over_passive;
    logic                  tx_over_bus_off;
    logic                  any_passive;
    logic                  majority;
    logic                  run_end;
    logic [7:0]            irq_active;
    logic [7:0]            next_rdata;
    logic [TX_BUFFERS-1:0] tx_event;
    logic [TX_BUFFERS-1:0] tx_clear;

    assign soft_reset_req = mode_ctrl[SOFT_RESET_BIT];
    assign sleep_mode     = mode_ctrl[SLEEP_REQ_BIT];
    assign hard_or_soft   = !rst_n || soft_reset_req;
    assign transfer_abort = soft_reset_req;
    assign bus_off_flag   = receiver_status_flags[BUS_OFF_BIT];

    // ****************************************
    // Write decode
    // ****************************************
    // Locked registers qualify on soft reset here, so no path can bypass it
    assign mode_write     = reg_write && reg_addr == ADDR_MODE_CTRL;
    assign prescale_write = reg_write && reg_addr == ADDR_PRESCALE && soft_reset_req;
    assign timing_write   = reg_write && reg_addr == ADDR_BIT_TIMING && soft_reset_req;
    assign rx_flags_write = reg_write && reg_addr == ADDR_RX_FLAGS;
    assign rx_en_write    = reg_write && reg_addr == ADDR_RX_IRQ_EN;
    assign tx_flags_write = reg_write && reg_addr == ADDR_TX_FLAGS;

    // ****************************************
    // Mode control and prescaler
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_ctrl <= MODE_CTRL_RESET;
        end else if (mode_write) begin
            mode_ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prescale <= BYTE_ZERO;
        end else if (prescale_write) begin
            prescale <= reg_wdata;
        end
    end

    // ****************************************
    // Bit timing
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bit_timing_segments <= BYTE_ZERO;
        end else if (timing_write) begin
            bit_timing_segments <= reg_wdata;
        end
    end

    assign triple_vote_sel = bit_timing_segments[TRIPLE_BIT];
    assign phase_span_one  = bit_timing_segments[SPAN_ONE_LSB +: 4];
    assign phase_span_two  = bit_timing_segments[SPAN_TWO_LSB +: 3];
    assign seg_one_quanta  = {1'b0, phase_span_one} + 5'd1;
    assign seg_two_quanta  = {1'b0, phase_span_two} + 4'd1;
    // Sync segment of one quantum precedes both segments
    assign quanta_per_bit  = 6'd1 + {1'b0, seg_one_quanta} + {2'b00, seg_two_quanta};
    assign prescale_value  = prescale[5:0];
    // Vote on the two earlier quanta and the live level at the sample point
    assign majority        = (sample_hist[1] & sample_hist[0]) | (sample_hist[1] & bus_rx)
                             | (sample_hist[0] & bus_rx);

    // Samples shift on each quantum; vote taken at the sample point
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sample_hist <= 3'h7;
            sampled_bit <= 1'b1;
        end else begin
            if (quantum_tick) begin
                sample_hist <= {sample_hist[1:0], bus_rx};
            end
            if (sample_tick) begin
                if (triple_vote_sel) begin
                    sampled_bit <= majority;
                end else begin
                    sampled_bit <= bus_rx;
                end
            end
        end
    end

    // ****************************************
    // Bus-off recovery: 128 runs of 11 recessive bits
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (hard_or_soft || !bus_off_flag) begin
            run_count <= 4'h0;
            run_total <= BYTE_ZERO;
            recovered <= 1'b0;
        end else if (bit_tick) begin
            // A dominant bit restarts the current run, not the total
            if (!sampled_bit) begin
                run_count <= 4'h0;
            end else if (run_end) begin
                run_count <= 4'h0;
                if (run_total == RUNS_LAST) begin
                    recovered <= 1'b1;
                end else begin
                    run_total <= run_total + 8'd1;
                end
            end else begin
                run_count <= run_count + 4'd1;
            end
        end
    end

    // ****************************************
    // Receiver flags
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_prev <= 1'b1;
        end else begin
            bus_prev <= bus_rx;
        end
    end

    // ****************************************
    // Counter thresholds
    // ****************************************
    assign rx_over_warn    = rx_error_count > WARN_LIMIT;
    assign tx_over_warn    = tx_error_count > WARN_LIMIT;
    assign rx_over_passive = rx_error_count > PASSIVE_LIMIT;
    assign tx_over_passive = tx_error_count > PASSIVE_LIMIT;
    assign tx_over_bus_off = tx_error_count > BUS_OFF_LIMIT;
    assign any_passive     = receiver_status_flags[RX_PASSIVE_BIT] || receiver_status_flags[TX_PASSIVE_BIT];
    assign run_end         = run_count == RUN_LAST;

    // Falling edge only, so a bus held dominant sets the flag once
    assign flag_set[WAKE_BIT]       = sleep_mode && bus_prev && !bus_rx;
    assign flag_set[RX_WARN_BIT]    = rx_over_warn
                                      && !(any_passive || bus_off_flag);
    assign flag_set[TX_WARN_BIT]    = tx_over_warn
                                      && !(any_passive || bus_off_flag);
    assign flag_set[RX_PASSIVE_BIT] = rx_over_passive && !bus_off_flag;
    assign flag_set[TX_PASSIVE_BIT] = tx_over_passive && !bus_off_flag;
    assign flag_set[BUS_OFF_BIT]    = tx_over_bus_off;
    assign flag_set[OVERRUN_BIT]    = overrun_event;
    assign flag_set[RX_FULL_BIT]    = rx_message_done && !receiver_status_flags[RX_FULL_BIT];

    // Conditions still holding block a clear
    assign flag_cond[WAKE_BIT]       = flag_set[WAKE_BIT];
    assign flag_cond[RX_WARN_BIT]    = rx_over_warn;
    assign flag_cond[TX_WARN_BIT]    = tx_over_warn;
    assign flag_cond[RX_PASSIVE_BIT] = rx_over_passive;
    assign flag_cond[TX_PASSIVE_BIT] = tx_over_passive;
    assign flag_cond[BUS_OFF_BIT]    = !recovered;
    assign flag_cond[OVERRUN_BIT]    = overrun_event;
    assign flag_cond[RX_FULL_BIT]    = 1'b0;

    assign wr_clear = rx_flags_write ? reg_wdata : BYTE_ZERO;

    // Set beats clear, so an event in the clearing cycle is kept, save a message done while the receive-full flag is already set
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_rx_flag
            always_ff @(posedge clk_sys) begin
                if (hard_or_soft) begin
                    receiver_status_flags[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    receiver_status_flags[gi] <= 1'b1;
                end else if (wr_clear[gi] && !flag_cond[gi]) begin
                    receiver_status_flags[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Exchange only into a released foreground buffer
    assign exchange_allowed = !receiver_status_flags[RX_FULL_BIT] && !soft_reset_req;

    // ****************************************
    // Interrupt enables and outputs
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (hard_or_soft) begin
            receiver_interrupt_enables <= BYTE_ZERO;
        end else if (rx_en_write) begin
            receiver_interrupt_enables <= reg_wdata;
        end
    end

    // Level outputs, so they drop as soon as flags clear
    assign irq_active = receiver_status_flags & receiver_interrupt_enables;
    assign wake_irq  = irq_active[WAKE_BIT];
    assign error_irq = |(irq_active & ERROR_FLAG_MASK);
    assign rx_irq    = irq_active[RX_FULL_BIT];

    // ****************************************
    // Transmit flags
    // ****************************************
    assign tx_event = tx_done | tx_aborted;
    assign tx_clear = tx_flags_write ? reg_wdata[TX_BUFFERS-1:0] : {TX_BUFFERS{1'b0}};

    // Clearing an empty flag takes its abort ack along, so no stale ack survives
    generate
        for (gi = 0; gi < TX_BUFFERS; gi++) begin : g_tx_flag
            always_ff @(posedge clk_sys) begin
                if (hard_or_soft) begin
                    tx_empty_flag[gi]  <= TX_EMPTY_RESET[gi];
                    abort_ack_flag[gi] <= 1'b0;
                end else if (tx_event[gi]) begin
                    tx_empty_flag[gi]  <= 1'b1;
                    abort_ack_flag[gi] <= tx_aborted[gi];
                end else if (tx_clear[gi]) begin
                    tx_empty_flag[gi]  <= 1'b0;
                    abort_ack_flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign transmit_status_flags = {1'b0, abort_ack_flag, 1'b0, tx_empty_flag};

    // ****************************************
    // Read port
    // ****************************************
    // Counters show only their low byte; the transmit counter's ninth bit is seen as bus-off
    always_comb begin
        next_rdata = BYTE_ZERO;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_MODE_CTRL:    next_rdata = mode_ctrl;
                ADDR_PRESCALE:     next_rdata = prescale;
                ADDR_BIT_TIMING:   next_rdata = bit_timing_segments;
                ADDR_RX_FLAGS:     next_rdata = receiver_status_flags;
                ADDR_RX_IRQ_EN:    next_rdata = receiver_interrupt_enables;
                ADDR_TX_FLAGS:     next_rdata = transmit_status_flags;
                ADDR_RX_ERR_COUNT: next_rdata = rx_error_count[7:0];
                ADDR_TX_ERR_COUNT: next_rdata = tx_error_count[7:0];
                default:           next_rdata = BYTE_ZERO;
            endcase
        end
    end

    // Read data stands one cycle for each cycle of reg_read, then returns to zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= BYTE_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : can_timing_error_flags
`default_nettype wire

// ===== rtl/can_timing_flags_pkg.sv
`default_nettype none
package can_timing_flags_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_MODE_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_PRESCALE     = 4'h2;
    localparam logic [3:0] ADDR_BIT_TIMING   = 4'h3;
    localparam logic [3:0] ADDR_RX_FLAGS     = 4'h4;
    localparam logic [3:0] ADDR_RX_IRQ_EN    = 4'h5;
    localparam logic [3:0] ADDR_TX_FLAGS     = 4'h6;
    localparam logic [3:0] ADDR_RX_ERR_COUNT = 4'hE;
    localparam logic [3:0] ADDR_TX_ERR_COUNT = 4'hF;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int SOFT_RESET_BIT  = 0;
    localparam int SLEEP_REQ_BIT   = 1;
    localparam int TRIPLE_BIT      = 7;
    localparam int SPAN_ONE_LSB    = 0;
    localparam int SPAN_TWO_LSB    = 4;
    localparam int WAKE_BIT        = 7;
    localparam int RX_WARN_BIT     = 6;
    localparam int TX_WARN_BIT     = 5;
    localparam int RX_PASSIVE_BIT  = 4;
    localparam int TX_PASSIVE_BIT  = 3;
    localparam int BUS_OFF_BIT     = 2;
    localparam int OVERRUN_BIT     = 1;
    localparam int RX_FULL_BIT     = 0;
    localparam int ABORT_ACK_LSB   = 4;
    localparam int TX_BUFFERS      = 3;
    localparam logic [7:0] MODE_CTRL_RESET  = 8'h01;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;
    localparam logic [2:0] TX_EMPTY_RESET   = 3'h7;
    localparam logic [7:0] ERROR_FLAG_MASK  = 8'h7E;
    // ****************************************
    // Error counter thresholds and bus-off recovery counts
    // ****************************************
    localparam logic [8:0] WARN_LIMIT    = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
    localparam int RECESSIVE_RUN     = 11;
    localparam int RECOVERY_RUNS     = 128;
    localparam logic [3:0] RUN_LAST  = 4'(RECESSIVE_RUN - 1);
    localparam logic [7:0] RUNS_LAST = 8'(RECOVERY_RUNS - 1);
endpackage : can_timing_flags_pkg
`default_nettype wire
